// >>> core/dual_link_irq_status_regs.vh
/*
 * Offsets, bit positions, masks and reset values of the two event
 * status registers of the converter pairs.
 * Assumes a 12-bit serial control port address and 8-bit data.
 */
`ifndef DUAL_LINK_IRQ_STATUS_REGS_VH
`define DUAL_LINK_IRQ_STATUS_REGS_VH

// ==========================================================
// port widths and register offsets
`define ADDR_WIDTH              12
`define DATA_WIDTH              8
`define DUAL_A_EVENT_STATUS     12'h025
`define DUAL_B_EVENT_STATUS     12'h026

// ==========================================================
// dual A field positions
`define A_ALIGN_LOCKED_BIT      3
`define A_ALIGN_ROTATED_BIT     2
`define A_OUT_OF_WINDOW_BIT     1
`define A_ALIGN_TRIPPED_BIT     0

// ==========================================================
// dual B field positions
`define B_POWER_ERROR_BIT       7
`define B_BLANKING_DONE_BIT     5
`define B_OSC_ALIGN_BIT         4
`define B_ALIGN_LOCKED_BIT      3
`define B_ALIGN_ROTATED_BIT     2
`define B_OUT_OF_WINDOW_BIT     1
`define B_ALIGN_TRIPPED_BIT     0

// ==========================================================
// implemented bit masks and reset values
`define DUAL_A_IMPL_MASK        8'h0F
`define DUAL_B_IMPL_MASK        8'hBF
`define STATUS_RESET            8'h00

`endif

// >>> core/event_status_cell.v
/*
 * One event status register: per bit either live view of its
 * condition or a rising-edge latch cleared by write-one.
 * Assumes conditions and enables come from logic on i_clock.
 */
`timescale 1ns/1ns

module event_status_cell #(
    parameter WIDTH            = 8,
    parameter [WIDTH-1:0] MASK = {WIDTH{1'b1}}
) (
    input  wire             i_clock,
    input  wire             i_rst,
    input  wire [WIDTH-1:0] i_cond,
    input  wire [WIDTH-1:0] i_latch_en,
    input  wire [WIDTH-1:0] i_clear,
    output wire [WIDTH-1:0] o_status,
    output wire             o_pending
);

    // ======================================================
    // edge detect and latch
    reg  [WIDTH-1:0] prev_q;
    reg  [WIDTH-1:0] latch_q;
    reg  [WIDTH-1:0] latch_d;
    wire [WIDTH-1:0] rise;

    assign rise = i_cond & ~prev_q;

    always @* begin
        // set wins over clear so a same-cycle event is kept
        latch_d = ((latch_q & ~i_clear) | rise) & i_latch_en & MASK;
    end

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            prev_q  <= {WIDTH{1'b0}};
            latch_q <= {WIDTH{1'b0}};
        end else begin
            prev_q  <= i_cond & MASK;
            latch_q <= latch_d;
        end
    end

    // ======================================================
    // read view
    assign o_status  = ((i_latch_en & latch_q) | (~i_latch_en & i_cond)) & MASK;
    assign o_pending = |(latch_q & i_latch_en);

endmodule

// >>> core/dual_link_irq_status.v
/*
 * Interrupt status logic of the two converter pairs: event bits,
 * serial-port register access and the shared active-low interrupt.
 * Assumes the serial port front end delivers decoded byte accesses
 * on i_clock, and that event conditions are synchronous to it.
 */
`timescale 1ns/1ns
`include "dual_link_irq_status_regs.vh"

module dual_link_irq_status (
    input  wire                   i_clock,
    input  wire                   i_rst,
    // register access from the serial port
    input  wire [`ADDR_WIDTH-1:0] i_reg_addr,
    input  wire [`DATA_WIDTH-1:0] i_reg_wdata,
    input  wire                   i_reg_wr,
    input  wire                   i_reg_rd,
    output reg  [`DATA_WIDTH-1:0] o_reg_rdata,
    output reg                    o_reg_rd_valid,
    output reg                    o_reg_unmapped,
    // dual A conditions
    input  wire                   i_pair_a_align_locked,
    input  wire                   i_pair_a_align_rotated,
    input  wire                   i_pair_a_phase_out_of_window,
    input  wire                   i_pair_a_align_tripped,
    // dual B conditions
    input  wire                   i_pair_b_power_error,
    input  wire                   i_pair_b_blanking_complete,
    input  wire                   i_pair_b_osc_align_tripped,
    input  wire                   i_pair_b_align_locked,
    input  wire                   i_pair_b_align_rotated,
    input  wire                   i_pair_b_phase_out_of_window,
    input  wire                   i_pair_b_align_tripped,
    // dual A latch enables
    input  wire                   i_pair_a_locked_latch_enable,
    input  wire                   i_pair_a_rotated_latch_enable,
    input  wire                   i_pair_a_window_latch_enable,
    input  wire                   i_pair_a_tripped_latch_enable,
    // dual B latch enables
    input  wire                   i_pair_b_power_latch_enable,
    input  wire                   i_pair_b_blanking_latch_enable,
    input  wire                   i_pair_b_osc_latch_enable,
    input  wire                   i_pair_b_locked_latch_enable,
    input  wire                   i_pair_b_rotated_latch_enable,
    input  wire                   i_pair_b_window_latch_enable,
    input  wire                   i_pair_b_tripped_latch_enable,
    // shared interrupt line
    output reg                    o_irq_n
);

    // ======================================================
    // address decode
    function addr_is;
        input [`ADDR_WIDTH-1:0] addr;
        input [`ADDR_WIDTH-1:0] target;
        begin
            addr_is = (addr == target);
        end
    endfunction

    wire hit_a;
    wire hit_b;

    assign hit_a = addr_is(i_reg_addr, `DUAL_A_EVENT_STATUS);
    assign hit_b = addr_is(i_reg_addr, `DUAL_B_EVENT_STATUS);

    // ======================================================
    // dual A condition and enable packing
    // conditions must already run on i_clock; no synchroniser here
    reg [`DATA_WIDTH-1:0] cond_a;
    reg [`DATA_WIDTH-1:0] en_a;

    always @* begin
        cond_a = `STATUS_RESET;
        en_a   = `STATUS_RESET;
        cond_a[`A_ALIGN_LOCKED_BIT]  = i_pair_a_align_locked;
        cond_a[`A_ALIGN_ROTATED_BIT] = i_pair_a_align_rotated;
        cond_a[`A_OUT_OF_WINDOW_BIT] = i_pair_a_phase_out_of_window;
        cond_a[`A_ALIGN_TRIPPED_BIT] = i_pair_a_align_tripped;
        en_a[`A_ALIGN_LOCKED_BIT]    = i_pair_a_locked_latch_enable;
        en_a[`A_ALIGN_ROTATED_BIT]   = i_pair_a_rotated_latch_enable;
        en_a[`A_OUT_OF_WINDOW_BIT]   = i_pair_a_window_latch_enable;
        en_a[`A_ALIGN_TRIPPED_BIT]   = i_pair_a_tripped_latch_enable;
    end

    // ======================================================
    // dual B condition and enable packing
    reg [`DATA_WIDTH-1:0] cond_b;
    reg [`DATA_WIDTH-1:0] en_b;

    always @* begin
        cond_b = `STATUS_RESET;
        en_b   = `STATUS_RESET;
        cond_b[`B_POWER_ERROR_BIT]   = i_pair_b_power_error;
        cond_b[`B_BLANKING_DONE_BIT] = i_pair_b_blanking_complete;
        cond_b[`B_OSC_ALIGN_BIT]     = i_pair_b_osc_align_tripped;
        cond_b[`B_ALIGN_LOCKED_BIT]  = i_pair_b_align_locked;
        cond_b[`B_ALIGN_ROTATED_BIT] = i_pair_b_align_rotated;
        cond_b[`B_OUT_OF_WINDOW_BIT] = i_pair_b_phase_out_of_window;
        cond_b[`B_ALIGN_TRIPPED_BIT] = i_pair_b_align_tripped;
        en_b[`B_POWER_ERROR_BIT]     = i_pair_b_power_latch_enable;
        en_b[`B_BLANKING_DONE_BIT]   = i_pair_b_blanking_latch_enable;
        en_b[`B_OSC_ALIGN_BIT]       = i_pair_b_osc_latch_enable;
        en_b[`B_ALIGN_LOCKED_BIT]    = i_pair_b_locked_latch_enable;
        en_b[`B_ALIGN_ROTATED_BIT]   = i_pair_b_rotated_latch_enable;
        en_b[`B_OUT_OF_WINDOW_BIT]   = i_pair_b_window_latch_enable;
        en_b[`B_ALIGN_TRIPPED_BIT]   = i_pair_b_tripped_latch_enable;
    end

    // ======================================================
    // write-one-to-clear strobes
    function [`DATA_WIDTH-1:0] w1c_strobe;
        input                   wr;
        input                   hit;
        input [`DATA_WIDTH-1:0] wdata;
        input [`DATA_WIDTH-1:0] mask;
        begin
            // zero bits and reserved bits leave the latches alone
            w1c_strobe = (wr && hit) ? (wdata & mask) : `STATUS_RESET;
        end
    endfunction

    wire [`DATA_WIDTH-1:0] clear_a;
    wire [`DATA_WIDTH-1:0] clear_b;

    assign clear_a = w1c_strobe(i_reg_wr, hit_a, i_reg_wdata, `DUAL_A_IMPL_MASK);
    assign clear_b = w1c_strobe(i_reg_wr, hit_b, i_reg_wdata, `DUAL_B_IMPL_MASK);

    // ======================================================
    // status registers
    wire [`DATA_WIDTH-1:0] status_a;
    wire [`DATA_WIDTH-1:0] status_b;
    wire                   pending_a;
    wire                   pending_b;

    event_status_cell #(
        .WIDTH (`DATA_WIDTH),
        .MASK  (`DUAL_A_IMPL_MASK)
    ) u_dual_a (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_cond     (cond_a),
        .i_latch_en (en_a),
        .i_clear    (clear_a),
        .o_status   (status_a),
        .o_pending  (pending_a)
    );

    event_status_cell #(
        .WIDTH (`DATA_WIDTH),
        .MASK  (`DUAL_B_IMPL_MASK)
    ) u_dual_b (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_cond     (cond_b),
        .i_latch_en (en_b),
        .i_clear    (clear_b),
        .o_status   (status_b),
        .o_pending  (pending_b)
    );

    // ======================================================
    // read data path
    reg [`DATA_WIDTH-1:0] rdata_d;

    always @* begin
        // unmapped addresses answer zero rather than stale data
        rdata_d = `STATUS_RESET;
        if (hit_a) begin
            rdata_d = status_a;
        end else if (hit_b) begin
            rdata_d = status_b;
        end
    end

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata    <= `STATUS_RESET;
            o_reg_rd_valid <= 1'b0;
            o_reg_unmapped <= 1'b0;
        end else begin
            o_reg_rd_valid <= i_reg_rd;
            o_reg_unmapped <= (i_reg_rd | i_reg_wr) & ~(hit_a | hit_b);
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_d;
            end
        end
    end

    // ======================================================
    // interrupt line
    // one line shared by both pairs, so software must poll both registers
    wire any_pending;

    assign any_pending = pending_a | pending_b;

    // one cycle behind the latch; keeps the pin glitch free
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_irq_n <= 1'b1;
        end else begin
            o_irq_n <= ~any_pending;
        end
    end

endmodule

// >>> bench/dual_link_irq_status_chk.sv
/* checker: read data and interrupt relations at the block ports
   assumes it is bound onto dual_link_irq_status, one clock domain */
`timescale 1ns/1ns
`include "dual_link_irq_status_regs.vh"
// ====
// port checker
module dual_link_irq_status_chk (
    input wire        i_clock, i_rst, i_reg_rd, i_reg_wr, o_reg_rd_valid, o_reg_unmapped, o_irq_n,
    input wire [11:0] i_reg_addr,
    input wire [7:0]  o_reg_rdata, i_reg_wdata,
    input wire        i_pair_a_align_locked, i_pair_a_locked_latch_enable, i_pair_b_power_error,
    input wire        i_pair_b_power_latch_enable, i_pair_b_align_tripped, i_pair_b_tripped_latch_enable
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    sequence rd_at(a, en); i_reg_rd && i_reg_addr == a && en; endsequence
    sequence lock_rise; i_pair_a_locked_latch_enable && $rose(i_pair_a_align_locked); endsequence
    sequence pow_rise; i_pair_b_power_latch_enable && $rose(i_pair_b_power_error); endsequence
    sequence trip_rise; i_pair_b_tripped_latch_enable && $rose(i_pair_b_align_tripped); endsequence
    sequence lock_kept; i_pair_a_locked_latch_enable
        && !(i_reg_wr && i_reg_addr == `DUAL_A_EVENT_STATUS && i_reg_wdata[3]); endsequence

    a_live_a_lock: assert property (rd_at(`DUAL_A_EVENT_STATUS, !i_pair_a_locked_latch_enable)
        |=> o_reg_rdata[3] == $past(i_pair_a_align_locked)) else $error("live lock bit wrong");
    a_live_b_power: assert property (rd_at(`DUAL_B_EVENT_STATUS, !i_pair_b_power_latch_enable)
        |=> o_reg_rdata[7] == $past(i_pair_b_power_error)) else $error("live power bit wrong");
    a_live_b_trip: assert property (rd_at(`DUAL_B_EVENT_STATUS, !i_pair_b_tripped_latch_enable)
        |=> o_reg_rdata[0] == $past(i_pair_b_align_tripped)) else $error("live trip bit wrong");
    a_lock_latch_held: assert property (lock_rise ##1 rd_at(`DUAL_A_EVENT_STATUS, i_pair_a_locked_latch_enable)
        |=> o_reg_rdata[3]) else $error("latched lock bit not read as one");
    a_lock_latch_kept: assert property (lock_rise ##1 lock_kept ##1 rd_at(`DUAL_A_EVENT_STATUS,
        i_pair_a_locked_latch_enable && !i_pair_a_align_locked) |=> o_reg_rdata[3])
        else $error("latched lock bit lost after condition fell");
    a_power_pulls_irq: assert property (pow_rise ##1 i_pair_b_power_latch_enable
        |=> !o_irq_n) else $error("power event did not pull interrupt");
    a_trip_pulls_irq: assert property (trip_rise ##1 i_pair_b_tripped_latch_enable
        |=> !o_irq_n) else $error("trip event did not pull interrupt");
    a_reserved_a_zero: assert property (o_reg_rd_valid && $past(i_reg_addr) == `DUAL_A_EVENT_STATUS
        |-> o_reg_rdata[7:4] == 4'h0) else $error("dual A reserved bits not zero");
    a_reserved_b_zero: assert property (o_reg_rd_valid && $past(i_reg_addr) == `DUAL_B_EVENT_STATUS
        |-> !o_reg_rdata[6]) else $error("dual B reserved bit not zero");
    a_unmapped_reads_zero: assert property (rd_at(i_reg_addr, i_reg_addr != `DUAL_A_EVENT_STATUS
        && i_reg_addr != `DUAL_B_EVENT_STATUS) |=> o_reg_unmapped && o_reg_rdata == 8'h00)
        else $error("unmapped read not refused");
endmodule

bind dual_link_irq_status dual_link_irq_status_chk i_dual_link_irq_status_chk (.*);

// >>> bench/host_port.sv
/* host partner: byte accesses of the serial port front end
   assumes one access at a time, called from the bench top */
`timescale 1ns/1ns
// ====
// host port model
module host_port (
    input  wire         i_clock,
    output logic [11:0] o_addr,
    output logic [7:0]  o_wdata,
    output logic        o_wr,
    output logic        o_rd
);
    initial {o_addr, o_wdata, o_wr, o_rd} = 22'h0;
    // released address and data lines flip so a stale value never passes
    task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(negedge i_clock);
        o_wr    = w;
        o_rd    = !w;
        o_addr  = a;
        o_wdata = d;
        @(negedge i_clock);
        o_wr    = 0;
        o_rd    = 0;
        o_addr  = ~a;
        o_wdata = ~d;
    endtask
endmodule

// >>> bench/test_dual_link_irq_status.sv
/* testbench: host partner, reference model, queued read checks
   assumes host_port and the bound checker */
`timescale 1ns/1ns
`include "dual_link_irq_status_regs.vh"
// ====
// bench top
module test_dual_link_irq_status;
    logic        i_clock = 0;
    logic        i_rst = 1;
    logic [10:0] c = 0, e = 0, pv, lat;
    logic        irq_m;
    logic [7:0]  q[$];
    logic [7:0]  x;
    int          n_fail = 0, checks = 0, cyc = 0, k;
    wire  [11:0] ad;
    wire  [7:0]  wd, rdat;
    wire         wr, rd, rv, irq_n;
    wire  [10:0] v = (e & lat) | (~e & c);
    wire  [10:0] clr = !wr ? 11'h000 : ad == `DUAL_A_EVENT_STATUS ? {wd[3:0], 7'h00}
                     : ad == `DUAL_B_EVENT_STATUS ? {4'h0, wd[7], wd[5:0]} : 11'h000;

    initial forever #50 i_clock = ~i_clock;
    host_port i_host_port (.i_clock(i_clock), .o_addr(ad), .o_wdata(wd), .o_wr(wr), .o_rd(rd));
    dual_link_irq_status i_dual_link_irq_status (.i_clock(i_clock), .i_rst(i_rst),
        .i_reg_addr(ad), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat),
        .o_reg_rd_valid(rv), .o_reg_unmapped(), .o_irq_n(irq_n),
        .i_pair_a_align_locked(c[10]), .i_pair_a_align_rotated(c[9]),
        .i_pair_a_phase_out_of_window(c[8]), .i_pair_a_align_tripped(c[7]),
        .i_pair_b_power_error(c[6]), .i_pair_b_blanking_complete(c[5]),
        .i_pair_b_osc_align_tripped(c[4]), .i_pair_b_align_locked(c[3]),
        .i_pair_b_align_rotated(c[2]), .i_pair_b_phase_out_of_window(c[1]),
        .i_pair_b_align_tripped(c[0]), .i_pair_a_locked_latch_enable(e[10]),
        .i_pair_a_rotated_latch_enable(e[9]), .i_pair_a_window_latch_enable(e[8]),
        .i_pair_a_tripped_latch_enable(e[7]), .i_pair_b_power_latch_enable(e[6]),
        .i_pair_b_blanking_latch_enable(e[5]), .i_pair_b_osc_latch_enable(e[4]),
        .i_pair_b_locked_latch_enable(e[3]), .i_pair_b_rotated_latch_enable(e[2]),
        .i_pair_b_window_latch_enable(e[1]), .i_pair_b_tripped_latch_enable(e[0]));

    // ====
    // reference model, set wins over clear
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pv    <= 0;
            lat   <= 0;
            irq_m <= 1;
        end else begin
            pv    <= c;
            lat   <= e & ((lat & ~clr) | (c & ~pv));
            irq_m <= ~|(lat & e);
            if (rd)
                q.push_back(ad == `DUAL_A_EVENT_STATUS ? {4'h0, v[10:7]} :
                    ad == `DUAL_B_EVENT_STATUS ? {v[6], 1'b0, v[5:0]} : 8'h00);
        end
    end

    task chk(input string s, input logic [7:0] a, input logic [7:0] b);
        checks++;
        if (a !== b) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", s, a, b);
        end
    endtask

    task close_out;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ====
    // monitor and hang guard
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            close_out;
        end
        if (rv === 1'b1) begin
            x = q.pop_front();
            chk("rdata", x, rdat);
            chk("irq_n", {7'h00, irq_m}, {7'h00, irq_n});
        end
    end

    initial begin
        void'($urandom(32'h6452d69a));
        repeat (2) @(negedge i_clock);
        i_rst = 0;
        // first phase all live, later phases random enables
        for (k = 0; k < 3; k++) begin
            e = k ? 11'($urandom) : 11'h000;
            repeat (30) begin
                c = 11'($urandom);
                i_host_port.acc(1'($urandom), 12'h024 + 12'($urandom % 4), 8'($urandom));
            end
        end
        e = 11'h7FF;
        c = 11'h000;
        repeat (2) @(negedge i_clock);
        c = 11'h7FF;
        @(negedge i_clock);
        c = 11'h000;
        i_host_port.acc(0, `DUAL_A_EVENT_STATUS, 8'h00);
        i_host_port.acc(1, `DUAL_A_EVENT_STATUS, 8'h00);
        i_host_port.acc(1, `DUAL_B_EVENT_STATUS, 8'h40);
        // one bit cleared at a time, interrupt freed only by the last
        for (k = 0; k < 12; k++) begin
            i_host_port.acc(0, k < 8 ? `DUAL_B_EVENT_STATUS : `DUAL_A_EVENT_STATUS, 8'h00);
            i_host_port.acc(1, k < 8 ? `DUAL_B_EVENT_STATUS : `DUAL_A_EVENT_STATUS, 8'(1 << k % 8));
        end
        i_host_port.acc(0, `DUAL_A_EVENT_STATUS, 8'h00);
        repeat (3) @(negedge i_clock);
        close_out;
    end
endmodule
